// >>> design/mmic_map.svh
// register offsets, field positions, reset values and timing counts of the interrupt controller
`ifndef MMIC_MAP_SVH
`define MMIC_MAP_SVH
`define MMIC_OFF_TMR     8'h32
`define MMIC_OFF_DMA0    8'h34
`define MMIC_OFF_DMA1    8'h36
`define MMIC_OFF_EXTA    8'h38
`define MMIC_OFF_EXTB    8'h3A
`define MMIC_OFF_EXTC    8'h3C
`define MMIC_OFF_EXTD    8'h3E
`define MMIC_OFF_EXTE    8'h40
`define MMIC_OFF_WDOG    8'h42
`define MMIC_OFF_SER     8'h44
`define MMIC_OFF_REQ     8'h2E
`define MMIC_OFF_INSV    8'h2C
`define MMIC_OFF_PRIMSK  8'h2A
`define MMIC_OFF_MASK    8'h28
`define MMIC_OFF_PSTAT   8'h26
`define MMIC_OFF_POLL    8'h24
`define MMIC_OFF_DONE    8'h22
`define MMIC_CTL_SFN     6
`define MMIC_CTL_CAS     5
`define MMIC_CTL_LVL     4
`define MMIC_CTL_MSK     3
`define MMIC_CTL_RST     7'h0F
`define MMIC_PRI_RST     3'h7
`define MMIC_DONE_NSPEC  15
`define MMIC_POLL_FLAG   15
`define MMIC_ACK_IDLE    2
`define MMIC_ACK_LEN     2
`define MMIC_NSRC        10
`define MMIC_TYPE_BASE   5'h08
`endif

// >>> design/mmic_pkg.sv
// types shared by the interrupt controller files
package mmic_pkg;
  typedef enum logic [5:0] {
    MMIC_IDLE  = 6'h01,
    MMIC_ACK1  = 6'h02,
    MMIC_GAP   = 6'h04,
    MMIC_ACK2  = 6'h08,
    MMIC_GRANT = 6'h10,
    MMIC_HOLD  = 6'h20
  } mmic_state_t;
endpackage

// >>> design/mmic_prio.sv
// priority resolver: lowest programmed level wins, ties go to lowest source index
`timescale 1ns/1ps
`default_nettype none
module mmic_prio #(
  parameter int N = 10
) (
  // candidates
  input  wire logic [N-1:0]   reqVec,
  input  wire logic [3*N-1:0] priVec,
  // result
  output logic                found,
  output logic [3:0]          winIdx,
  output logic [2:0]          winPri
);
  always_comb begin
    found  = 1'b0;
    winIdx = 4'h0;
    winPri = 3'h7;
    for (int i = 0; i < N; i++) begin
      if (reqVec[i] && (!found || priVec[3*i +: 3] < winPri)) begin
        found  = 1'b1;
        winIdx = 4'(i);
        winPri = priVec[3*i +: 3];
      end
    end
  end
endmodule
`default_nettype wire

// >>> design/mmic_core.sv
// master mode interrupt controller: control registers, nesting, poll, end of service, cascade acknowledge
//
// Our own choices: the address map and the address-and-strobe port.
`include "mmic_map.svh"
`timescale 1ns/1ps
`default_nettype none
module mmic_core (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [15:0]      regRdData,
  // internal peripheral requests, pulses or levels from core logic
  input  wire logic        tmrReq,
  input  wire logic        dma0Req,
  input  wire logic        dma1Req,
  input  wire logic        wdogReq,
  input  wire logic        serReq,
  // external pins
  input  wire logic        extReqA,
  input  wire logic        extReqB,
  input  wire logic        extReqCIn,
  input  wire logic        extReqDIn,
  input  wire logic        extReqE,
  output logic             cascadeAckAOut,
  output logic             cascadeAckAOe,
  output logic             cascadeAckBOut,
  output logic             cascadeAckBOe,
  input  wire logic [7:0]  lowMuxedBusLines,
  // processor core
  output logic             intReq,
  input  wire logic        intTake,
  output logic [7:0]       intType,
  output logic             intTypeValid,
  output logic             aleStrobe,
  output logic             rdStrobeB,
  output logic             slaveMode
);
  localparam int NS = `MMIC_NSRC;
  // source index: 0 tmr, 1 dma0, 2 dma1, 3..7 ext a..e, 8 wdog, 9 ser
  ////////////////////////////////////////////////////////////////////////////
  logic [4:0] pinS1_q;
  logic [4:0] pinS2_q;
  logic [4:0] pinOld_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinS1_q  <= 5'h00;
      pinS2_q  <= 5'h00;
      pinOld_q <= 5'h00;
    end else begin
      pinS1_q  <= {extReqE, extReqDIn, extReqCIn, extReqB, extReqA};
      pinS2_q  <= pinS1_q;
      pinOld_q <= pinS2_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  logic [6:0]    ctl_q [NS];
  logic [NS-1:0] pend_q;
  logic [NS-1:0] insv_q;
  logic [2:0]    thr_q;
  logic [7:0]    capType_q;
  mmic_pkg::mmic_state_t st_q;
  logic [1:0]    cnt_q;
  logic [3:0]    ackIdx_q;
  logic [3:0]    svcIdx_q;

  wire casA = ctl_q[3][`MMIC_CTL_CAS];
  wire casB = ctl_q[4][`MMIC_CTL_CAS];
  // pins c and d are not requests while they serve as acknowledge outputs
  wire [4:0] pinUse = {1'b1, ~casB, ~casA, 2'b11};
  wire [NS-1:0] rawReq = {serReq, wdogReq, pinS2_q & pinUse, dma1Req, dma0Req, tmrReq};
  wire [4:0] pinRise = pinS2_q & ~pinOld_q;

  logic [NS-1:0] newEvt;
  logic [NS-1:0] isLvl;
  logic [NS-1:0] maskBit;
  logic [NS-1:0] sfnBit;
  logic [3*NS-1:0] priVec;
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : gSrc
      assign maskBit[g] = ctl_q[g][`MMIC_CTL_MSK];
      assign priVec[3*g +: 3] = ctl_q[g][2:0];
      assign sfnBit[g] = (g == 3 || g == 4) ? ctl_q[g][`MMIC_CTL_SFN] : 1'b0;
      if (g >= 3 && g <= 7) begin : gPin
        assign isLvl[g]  = ctl_q[g][`MMIC_CTL_LVL];
        assign newEvt[g] = (isLvl[g] ? pinS2_q[g-3] : pinRise[g-3]) & pinUse[g-3];
      end else begin : gInt
        assign isLvl[g]  = 1'b0;
        assign newEvt[g] = rawReq[g];
      end
    end
  endgenerate

  // a source is blocked by a lower level, or an equal level at a lower index, in service, or by its own bit unless sfnBit is set
  logic [NS-1:0] eligible;
  always_comb begin
    eligible = '0;
    for (int i = 0; i < NS; i++) begin
      eligible[i] = pend_q[i] & ~maskBit[i] & (priVec[3*i +: 3] <= thr_q);
      for (int j = 0; j < NS; j++) begin
        if (insv_q[j] && j != i && (priVec[3*j +: 3] < priVec[3*i +: 3] ||
            (priVec[3*j +: 3] == priVec[3*i +: 3] && j < i)))
          eligible[i] = 1'b0;
      end
      if (insv_q[i] && !sfnBit[i])
        eligible[i] = 1'b0;
    end
  end

  logic       winFound;
  logic [3:0] winIdx;
  logic [2:0] winPri;
  mmic_prio #(.N(NS)) uReqPrio (
    .reqVec (eligible),
    .priVec (priVec),
    .found  (winFound),
    .winIdx (winIdx),
    .winPri ()
  );

  logic       isvFound;
  logic [3:0] isvIdx;
  mmic_prio #(.N(NS)) uSvcPrio (
    .reqVec (insv_q),
    .priVec (priVec),
    .found  (isvFound),
    .winIdx (isvIdx),
    .winPri (winPri)
  );

  wire [4:0] winType = `MMIC_TYPE_BASE + {1'b0, winIdx};
  wire [15:0] pollWord = {winFound, 10'h000, winFound ? winType : 5'h00};
  ////////////////////////////////////////////////////////////////////////////
  // register decode
  wire wrDone  = regWr && regAddr == `MMIC_OFF_DONE;
  wire wrMask  = regWr && regAddr == `MMIC_OFF_MASK;
  wire wrThr   = regWr && regAddr == `MMIC_OFF_PRIMSK;
  wire wrInsv  = regWr && regAddr == `MMIC_OFF_INSV;
  wire rdPoll  = regRd && regAddr == `MMIC_OFF_POLL;
  wire doneNs  = regWrData[`MMIC_DONE_NSPEC];
  wire [4:0] doneIdx = regWrData[4:0] - `MMIC_TYPE_BASE;

  function automatic logic [7:0] ctlOff(input int i);
    case (i)
      0: ctlOff = `MMIC_OFF_TMR;
      1: ctlOff = `MMIC_OFF_DMA0;
      2: ctlOff = `MMIC_OFF_DMA1;
      3: ctlOff = `MMIC_OFF_EXTA;
      4: ctlOff = `MMIC_OFF_EXTB;
      5: ctlOff = `MMIC_OFF_EXTC;
      6: ctlOff = `MMIC_OFF_EXTD;
      7: ctlOff = `MMIC_OFF_EXTE;
      8: ctlOff = `MMIC_OFF_WDOG;
      default: ctlOff = `MMIC_OFF_SER;
    endcase
  endfunction

  // processor take of an internally typed source, or the take that starts a cascade sequence
  wire grantInt = st_q == mmic_pkg::MMIC_IDLE && intTake && winFound &&
                  !((winIdx == 4'h3 && casA) || (winIdx == 4'h4 && casB));
  wire grantCas = st_q == mmic_pkg::MMIC_IDLE && intTake && winFound && !grantInt;
  wire setIdx   = rdPoll || grantInt || grantCas;
  wire [3:0] setSel = winIdx;

  logic [NS-1:0] clrVec;
  logic [NS-1:0] setVec;
  always_comb begin
    clrVec = '0;
    setVec = '0;
    if (wrDone && doneNs && isvFound)
      clrVec[isvIdx] = 1'b1;
    if (wrDone && !doneNs && doneIdx < 5'(NS))
      clrVec[doneIdx[3:0]] = 1'b1;
    if (setIdx && winFound)
      setVec[setSel] = 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NS; i++)
        ctl_q[i] <= `MMIC_CTL_RST;
      pend_q <= '0;
      insv_q <= '0;
      thr_q  <= `MMIC_PRI_RST;
    end else begin
      for (int i = 0; i < NS; i++) begin
        if (regWr && regAddr == ctlOff(i))
          ctl_q[i] <= (i == 3 || i == 4) ? regWrData[6:0] : {2'b00, regWrData[4:0]};
        else if (wrMask)
          ctl_q[i][`MMIC_CTL_MSK] <= regWrData[i];
        // level inputs follow the pin; edges stick until taken, set beats clear
        if (newEvt[i])
          pend_q[i] <= 1'b1;
        else if (setVec[i] || (isLvl[i] && !rawReq[i]))
          pend_q[i] <= 1'b0;
        // setting wins over a clear in the same cycle
        if (setVec[i])
          insv_q[i] <= 1'b1;
        else if (clrVec[i] || (wrInsv && !regWrData[i]))
          insv_q[i] <= 1'b0;
        else if (wrInsv)
          insv_q[i] <= 1'b1;
      end
      if (wrThr)
        thr_q <= regWrData[2:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // cascade acknowledge sequencer
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q      <= mmic_pkg::MMIC_IDLE;
      cnt_q     <= 2'h0;
      ackIdx_q  <= 4'h0;
      svcIdx_q  <= 4'h0;
      capType_q <= 8'h00;
    end else begin
      case (st_q)
        mmic_pkg::MMIC_IDLE: begin
          if (grantInt) begin
            capType_q <= {3'b000, winType};
            st_q      <= mmic_pkg::MMIC_GRANT;
          end else if (grantCas) begin
            ackIdx_q <= winIdx;
            st_q     <= mmic_pkg::MMIC_ACK1;
          end
        end
        mmic_pkg::MMIC_ACK1: begin
          cnt_q <= 2'h0;
          st_q  <= mmic_pkg::MMIC_GAP;
        end
        mmic_pkg::MMIC_GAP: begin
          cnt_q <= cnt_q + 2'h1;
          if (cnt_q == 2'(`MMIC_ACK_IDLE - 1))
            st_q <= mmic_pkg::MMIC_ACK2;
        end
        mmic_pkg::MMIC_ACK2: begin
          capType_q <= lowMuxedBusLines;
          st_q      <= mmic_pkg::MMIC_GRANT;
        end
        mmic_pkg::MMIC_GRANT: begin
          svcIdx_q <= ackIdx_q;
          st_q     <= mmic_pkg::MMIC_HOLD;
        end
        mmic_pkg::MMIC_HOLD: begin
          if (!intTake)
            st_q <= mmic_pkg::MMIC_IDLE;
        end
        default: st_q <= mmic_pkg::MMIC_IDLE;
      endcase
    end
  end

  wire inAck   = st_q == mmic_pkg::MMIC_ACK1 || st_q == mmic_pkg::MMIC_ACK2;
  wire ackOnA  = inAck && ackIdx_q == 4'h3;
  wire ackOnB  = inAck && ackIdx_q == 4'h4;
  assign cascadeAckAOe  = casA;
  assign cascadeAckAOut = !ackOnA;
  assign cascadeAckBOe  = casB;
  assign cascadeAckBOut = !ackOnB;
  assign aleStrobe      = inAck;
  assign rdStrobeB      = 1'b1;
  assign slaveMode      = 1'b0;
  assign intReq         = winFound && st_q == mmic_pkg::MMIC_IDLE;
  assign intTypeValid   = st_q == mmic_pkg::MMIC_GRANT;
  assign intType        = capType_q;
  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe
  logic [15:0] rdMux;
  always_comb begin
    rdMux = 16'h0000;
    for (int i = 0; i < NS; i++)
      if (regAddr == ctlOff(i))
        rdMux = {9'h000, ctl_q[i]};
    case (regAddr)
      `MMIC_OFF_REQ:    rdMux = {6'h00, pend_q};
      `MMIC_OFF_INSV:   rdMux = {6'h00, insv_q};
      `MMIC_OFF_PRIMSK: rdMux = {13'h0000, thr_q};
      `MMIC_OFF_MASK:   rdMux = {6'h00, maskBit};
      `MMIC_OFF_PSTAT:  rdMux = pollWord;
      `MMIC_OFF_POLL:   rdMux = pollWord;
      default:          rdMux = rdMux;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b)
      regRdData <= 16'h0000;
    else if (regRd)
      regRdData <= rdMux;
  end
endmodule
`default_nettype wire

// >>> bench/mmic_core_props.sv
// checker for the interrupt controller ports: acknowledge timing, strobes, reset state
`timescale 1ns/1ps
`default_nettype none
module mmic_core_props (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst_b,
  // watched ports
  input wire logic [7:0] lowMuxedBusLines,
  input wire logic       cascadeAckAOut,
  input wire logic       cascadeAckAOe,
  input wire logic       cascadeAckBOut,
  input wire logic       cascadeAckBOe,
  input wire logic       intReq,
  input wire logic       intTake,
  input wire logic [7:0] intType,
  input wire logic       intTypeValid,
  input wire logic       aleStrobe,
  input wire logic       rdStrobeB,
  input wire logic       slaveMode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // first ack has no strobe three cycles back, second one does
  sequence ackFirst;
    $fell(cascadeAckAOut) && !$past(aleStrobe, 3);
  endsequence
  sequence ackSecond;
    $fell(cascadeAckAOut) && $past(aleStrobe, 3);
  endsequence
  a_ack_gap: assert property (ackFirst |=> (cascadeAckAOut && !aleStrobe) [*2] ##1 !cascadeAckAOut)
    else $error("idle gap between acknowledge cycles broken");
  a_type_capture: assert property (ackSecond |=> intTypeValid && intType == $past(lowMuxedBusLines))
    else $error("cascaded type not taken from second cycle");
  a_ack_strobes: assert property (aleStrobe == (!cascadeAckAOut || !cascadeAckBOut) && rdStrobeB)
    else $error("latch or read strobe wrong around acknowledge");
  a_master_mode: assert property (!slaveMode)
    else $error("controller left master mode");
  a_valid_pulse: assert property (intTypeValid |=> !intTypeValid)
    else $error("type valid longer than one cycle");
  a_take_busy: assert property (intReq && intTake |=> !intReq)
    else $error("request still offered after take");
  a_plain_pins: assert property ((!cascadeAckAOe |-> cascadeAckAOut) and (!cascadeAckBOe |-> cascadeAckBOut))
    else $error("acknowledge pin active outside cascade");
  a_reset_state: assert property (@(posedge core_clk) disable iff (1'b0)
    !rst_b |-> !intReq && !cascadeAckAOe && !cascadeAckBOe && cascadeAckAOut && cascadeAckBOut)
    else $error("outputs not quiet in reset");
endmodule
bind mmic_core mmic_core_props mmic_core_props_inst (.core_clk, .rst_b, .lowMuxedBusLines, .cascadeAckAOut,
  .cascadeAckAOe, .cascadeAckBOut, .cascadeAckBOe, .intReq, .intTake, .intType, .intTypeValid, .aleStrobe,
  .rdStrobeB, .slaveMode);
`default_nettype wire

// >>> bench/mmic_ext_model.sv
// external cascaded controller: raises a request, answers the acknowledge pair with its type
`timescale 1ns/1ps
`default_nettype none
module mmic_ext_model #(
  parameter logic [7:0] TYPE_VAL = 8'h5A
) (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       ackN,
  input  wire logic       raise,
  output logic            req,
  output logic [7:0]      bus
);
  logic       ackSeen_q;
  logic       ackCnt_q;
  logic [7:0] noise_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      req       <= 1'b0;
      ackSeen_q <= 1'b0;
      ackCnt_q  <= 1'b0;
      noise_q   <= 8'hA5;
    end else begin
      ackSeen_q <= !ackN;
      noise_q   <= {noise_q[6:0], ~noise_q[7]};
      if (raise) begin
        req <= 1'b1;
      end
      if (!ackN && !ackSeen_q) begin
        ackCnt_q <= ~ackCnt_q;
        req      <= 1'b0;
      end
    end
  end
  // released bus keeps changing so a stale sample cannot match
  assign bus = (!ackN && ackCnt_q) ? TYPE_VAL : noise_q;
endmodule
`default_nettype wire

// >>> bench/mmic_tb.sv
// self-checking bench for the master mode interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [7:0] CTYPE = 8'h5A;
  logic        core_clk, rst_b, regWr, regRd, intTake, raiseA, extReqA;
  logic        extB, extC, extD, extE, ackAOut, ackAOe, ackBOut, ackBOe;
  logic        intReq, intTypeValid, aleStrobe, rdStrobeB, slaveMode;
  logic [4:0]  periph;
  logic [7:0]  regAddr, busLines, intType;
  logic [15:0] regWrData, regRdData, rdVal;
  logic [23:0] rows [16];
  int          errors, checks, cyc;
  mmic_core mmic_core_inst (.core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .tmrReq(periph[0]), .dma0Req(periph[1]),
    .dma1Req(periph[2]), .wdogReq(periph[3]), .serReq(periph[4]), .extReqA(extReqA), .extReqB(extB),
    .extReqCIn(extC), .extReqDIn(extD), .extReqE(extE), .cascadeAckAOut(ackAOut), .cascadeAckAOe(ackAOe),
    .cascadeAckBOut(ackBOut), .cascadeAckBOe(ackBOe), .lowMuxedBusLines(busLines), .intReq(intReq),
    .intTake(intTake), .intType(intType), .intTypeValid(intTypeValid), .aleStrobe(aleStrobe),
    .rdStrobeB(rdStrobeB), .slaveMode(slaveMode));
  mmic_ext_model #(.TYPE_VAL(CTYPE)) mmic_ext_model_inst (.core_clk(core_clk), .rst_b(rst_b), .ackN(ackAOut),
    .raise(raiseA), .req(extReqA), .bus(busLines));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // every task starts and ends just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 rdVal = regRdData;
    chk(rdVal, exp);
    @(posedge core_clk);
  endtask
  task automatic pulse(input logic [4:0] p);
    periph <= p;
    @(posedge core_clk);
    periph <= 5'h00;
    @(posedge core_clk);
  endtask
  task automatic quiet;
    repeat (6) @(posedge core_clk);
    #1 chk({15'h0000, intReq}, 16'h0000);
    @(posedge core_clk);
  endtask
  task automatic take(input logic [7:0] t);
    int n;
    n = 0;
    while (intReq !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      #1 n++;
    end
    @(posedge core_clk);
    intTake <= 1'b1;
    n = 0;
    while (intTypeValid !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk({8'h00, intType}, {8'h00, t});
    @(posedge core_clk);
    intTake <= 1'b0;
    @(posedge core_clk);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      report_and_stop;
    end
  end
  initial begin
    {regWr, regRd, intTake, raiseA, extB, extC, extD, extE} = 8'h00;
    {regAddr, regWrData, periph} = 29'h0000000;
    rst_b = 1'b0;
    rows = '{{8'h32, 16'h000F}, {8'h34, 16'h000F}, {8'h36, 16'h000F}, {8'h38, 16'h000F}, {8'h3A, 16'h000F},
      {8'h3C, 16'h000F}, {8'h3E, 16'h000F}, {8'h40, 16'h000F}, {8'h42, 16'h000F}, {8'h44, 16'h000F},
      {8'h2E, 16'h0000}, {8'h2C, 16'h0000}, {8'h2A, 16'h0007}, {8'h28, 16'h03FF}, {8'h26, 16'h0000},
      {8'h50, 16'h0000}};
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    foreach (rows[i]) rchk(rows[i][23:16], rows[i][15:0]);
    chk({14'h0000, slaveMode, rdStrobeB}, 16'h0001);
    ///////////////////////////////////////////////////////////////////////////
    wr(8'h32, 16'h0003);
    wr(8'h34, 16'h0005);
    pulse(5'h01);
    rchk(8'h26, 16'h8008);
    rchk(8'h2C, 16'h0000);
    take(8'h08);
    rchk(8'h2C, 16'h0001);
    pulse(5'h03);
    quiet;
    wr(8'h22, 16'h8000);
    take(8'h08);
    wr(8'h22, 16'h0009);
    rchk(8'h2C, 16'h0001);
    wr(8'h22, 16'h0008);
    take(8'h09);
    rchk(8'h2C, 16'h0002);
    wr(8'h22, 16'h8000);
    ///////////////////////////////////////////////////////////////////////////
    wr(8'h44, 16'h0002);
    pulse(5'h10);
    rchk(8'h24, 16'h8011);
    rchk(8'h2C, 16'h0200);
    wr(8'h22, 16'h0011);
    rchk(8'h2C, 16'h0000);
    ///////////////////////////////////////////////////////////////////////////
    wr(8'h38, 16'h0061);
    chk({14'h0000, ackAOe, ackBOe}, 16'h0002);
    raiseA <= 1'b1;
    @(posedge core_clk);
    raiseA <= 1'b0;
    take(CTYPE);
    rchk(8'h2C, 16'h0008);
    pulse(5'h01);
    quiet;
    raiseA <= 1'b1;
    @(posedge core_clk);
    raiseA <= 1'b0;
    take(CTYPE);
    wr(8'h22, 16'h8000);
    take(8'h08);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    foreach (rows[i]) rchk(rows[i][23:16], rows[i][15:0]);
    chk({14'h0000, ackAOe, ackBOe}, 16'h0000);
    wr(8'h28, 16'h03FE);
    rchk(8'h32, 16'h0007);
    wr(8'h2A, 16'h0006);
    pulse(5'h01);
    quiet;
    wr(8'h2A, 16'h0007);
    take(8'h08);
    wr(8'h22, 16'h8000);
    rchk(8'h2C, 16'h0000);
    report_and_stop;
  end
endmodule
`default_nettype wire
